// File: verilog/scs_pkg.sv
package scs_pkg;
    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets (one aligned word each)
    localparam logic [7:0] OFS_RESET_FLAGS = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_FAULTS = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0c;
    localparam logic [7:0] OFS_CLK_COUNT = 8'h10;
    localparam logic [7:0] OFS_GATE_LOW = 8'h18;
    localparam logic [7:0] OFS_GATE_HIGH = 8'h1c;

    // Reset flag bits, cleared when read
    localparam int RF_CLOCK = 0;
    localparam int RF_INT_UV = 1;
    localparam int RF_MAIN_UV = 2;
    localparam int RF_EXT = 3;
    localparam int RF_W = 4;

    // Control bits
    localparam int CT_SPREAD_EN = 0;
    localparam int CT_SPREAD_DEPTH = 1;
    localparam int CT_MON_STOP = 2;
    localparam int CT_W = 3;
    localparam logic [CT_W-1:0] CONTROL_RESET = 3'h0;

    // Fault bits; the low FC_W of them are sticky and have a clear bit each
    localparam int FL_PWR_UV = 0;
    localparam int FL_GND_LOSS = 1;
    localparam int FL_PWR_OV = 2;
    localparam int FL_TEMP = 3;
    localparam int FC_W = 3;

    // Supervision filter indices
    localparam int F_MAIN_UV = 0;
    localparam int F_INT_UV = 1;
    localparam int F_EXT = 2;
    localparam int F_PWR_OV = 3;
    localparam int F_PWR_UV = 4;
    localparam int F_GND = 5;
    localparam int F_TEMP = 6;
    localparam int NF = 7;

    // Timing figures as printed and their cycle counts; INT_UV_CYC comes to 40000, 1000 times the count for its 1 us figure
    localparam int CLK_PERIOD_NS = 25;
    localparam int SHORT_BASE_NS = 18200;
    localparam int LONG_BASE_NS = 293000;
    localparam int EXT_FILTER_NS = 2000;
    localparam int INT_UV_FILTER_US = 1;
    localparam int RECOVERY_MS = 45;
    localparam int SHORT_CYC = (SHORT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_CYC = (LONG_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_CYC = (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_UV_CYC = INT_UV_FILTER_US * 1000 * 1000 / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = RECOVERY_MS * 1000 * 1000 / CLK_PERIOD_NS;
    // Time-base filters need two ticks so that at least one full interval elapses
    localparam int BASE_TICKS = 2;

    // Oscillator cross-check: auxiliary nominal 14 MHz, tolerance 25 percent
    localparam int AUX_FREQ_KHZ = 14000;
    localparam int AUX_TOL_PCT = 25;
    localparam int AUX_EXPECT = LONG_BASE_NS / 1000 * AUX_FREQ_KHZ / 1000;

    // Spread deviation bands and rate in kHz
    localparam int SPREAD_NARROW_KHZ = 350;
    localparam int SPREAD_WIDE_KHZ = 700;
    localparam int SPREAD_RATE_KHZ = 110;

    typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_RECOVER} scs_seq_t;
endpackage

// File: verilog/scs_filt_if.sv
`timescale 1ns/1ps
interface scs_filt_if;
    logic raw;
    logic tick;
    logic held;
    modport user (output raw, output tick, input held);
    modport filt (input raw, input tick, output held);
endinterface

// File: verilog/scs_filter.sv
`timescale 1ns/1ps
module scs_filter #(
    parameter int unsigned LIMIT = 2,
    parameter bit BOTH_WAYS = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Detector side
    scs_filt_if.filt f
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] count;

    if (LIMIT < 1) begin : g_check
        $error("scs_filter: LIMIT must be at least one");
    end

    // A rise must persist for LIMIT ticks, a fall too with BOTH_WAYS (else it acts at once); any bounce restarts the count
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            f.held <= 1'b0;
            count <= '0;
        end else if (f.raw == f.held) begin
            count <= '0;
        end else if (!BOTH_WAYS && !f.raw) begin
            f.held <= 1'b0;
            count <= '0;
        end else if (f.tick) begin
            if (count == LAST) begin
                f.held <= f.raw;
                count <= '0;
            end else begin
                count <= count + 1'b1;
            end
        end
    end
endmodule

// File: verilog/scs_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Ground loss flag sets after condition persists one long time base.
// - Degraded ground keeps the register port alive and reports ground loss as 1.
// - After an open ground reconnects, ground loss flag still reads 1.
// - Low reset line counts as external reset only after the filter time.
// - Main supply undervoltage resets only after one short time base.
// - Internal supply undervoltage resets only after its own filter interval.
// - Power overvoltage filtered one long time base, both set and release.
// - Power undervoltage recognised after persisting one long time base.
// - Oscillators compared only with internal supplies good; mismatch beyond tolerance flagged.
// - Mismatch measured over long time base windows, at most one fault each.
// - Oscillator stopped longer than short time base gives reset and clock flag.
// - Mismatch fault reported between one short and two long time bases.
// - Spread depth select picks narrow or wide deviation, same modulation rate.
// - Temperature warning reported after persisting one long time base.
// - Writing 1 to a clear bit clears its flag for one clock.
// - Clear bit returns to 0 by itself one clock after the clear.
// - Both gate regulator readings are readable over the register port.
// - Each reset flag clears when a read returns it.
// - Clock monitoring restarts only after the clock flag has been read.
module scs_supervisor
    import scs_pkg::*;
#(
    parameter int LONG_CYCLES = scs_pkg::LONG_CYC,
    parameter int INT_UV_CYCLES = scs_pkg::INT_UV_CYC,
    parameter int RECOVERY_CYCLES = scs_pkg::RECOVERY_CYC,
    parameter int AUX_EXPECTED = scs_pkg::AUX_EXPECT
) (
    // Clock (main oscillator) and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [scs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [scs_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [scs_pkg::DATA_W-1:0] regRdata,
    // Analog comparator outputs, high while the condition holds
    input wire logic mainSupplyUv,
    input wire logic internalSupplyUv,
    input wire logic powerOv,
    input wire logic powerUv,
    input wire logic groundLossRaw,
    input wire logic dieTempHigh,
    // Auxiliary oscillator, sampled
    input wire logic auxClk,
    // Digitised gate regulator voltages
    input wire logic [9:0] gateRegulatorLow,
    input wire logic [9:0] gateRegulatorHigh,
    // Reset line toward the host, open drain
    input wire logic resetLineIn,
    output logic resetLineOut,
    output logic resetLineOe,
    // Oscillator spread control and flag outputs
    output logic spreadEnable,
    output logic spreadDepthSelect,
    output logic groundLossFlag,
    output logic clockFaultResetFlag
);
    localparam int RCW = $clog2(RECOVERY_CYCLES + 1);
    localparam int LCW = $clog2(LONG_CYCLES + 1);
    localparam int SCW = $clog2(SHORT_CYC + 1);
    localparam logic [LCW-1:0] LONG_LAST = LCW'(LONG_CYCLES - 1);
    localparam logic [SCW-1:0] SHORT_LAST = SCW'(SHORT_CYC - 1);
    localparam logic [RCW-1:0] REC_LAST = RCW'(RECOVERY_CYCLES - 1);
    localparam logic [15:0] AUX_MIN = 16'(AUX_EXPECTED * (100 - AUX_TOL_PCT) / 100);
    localparam logic [15:0] AUX_MAX = 16'(AUX_EXPECTED * (100 + AUX_TOL_PCT) / 100);
    localparam int unsigned LIM [NF] = '{BASE_TICKS, INT_UV_CYCLES, EXT_CYC, BASE_TICKS,
                                         BASE_TICKS, BASE_TICKS, BASE_TICKS};
    localparam bit BOTH [NF] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    if (LONG_CYCLES < 2 * SHORT_CYC || RECOVERY_CYCLES < 1 || INT_UV_CYCLES < 1
            || AUX_EXPECTED * (100 + AUX_TOL_PCT) / 100 > 65535) begin : g_check
        $error("scs_supervisor: timing parameters out of range");
    end

    // Time bases
    logic [SCW-1:0] shortCount;
    logic [LCW-1:0] longCount;
    logic shortTick;
    logic longTick;
    // Filters
    logic [NF-1:0] filtRaw;
    logic [NF-1:0] filtTick;
    logic [NF-1:0] filtHeld;
    // Oscillator check
    logic auxPrev;
    logic [15:0] auxCount;
    logic [15:0] auxLast;
    logic [SCW-1:0] auxIdle;
    logic clockFaultEvent;
    // Sequencer
    scs_seq_t seqState;
    scs_seq_t next_seqState;
    logic [RCW-1:0] recCount;
    // Registers
    logic [RF_W-1:0] resetFlags;
    logic [CT_W-1:0] control;
    logic [FC_W-1:0] stickyFaults;
    logic [FC_W-1:0] clearBits;
    logic clearStage;

    // Time base counters on main oscillator cycles
    assign shortTick = (shortCount == SHORT_LAST);
    assign longTick = (longCount == LONG_LAST);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shortCount <= '0;
            longCount <= '0;
        end else begin
            shortCount <= shortTick ? '0 : shortCount + 1'b1;
            longCount <= longTick ? '0 : longCount + 1'b1;
        end
    end

    // Filter inputs and their tick sources
    wire lineExtLow = !resetLineIn && !resetLineOe;
    assign filtRaw = {dieTempHigh, groundLossRaw, powerUv, powerOv, lineExtLow,
                      internalSupplyUv, mainSupplyUv};
    assign filtTick = {longTick, longTick, longTick, longTick, 1'b1, 1'b1, shortTick};

    genvar gi;
    for (gi = 0; gi < NF; gi++) begin : g_filt
        scs_filt_if fIf ();
        assign fIf.raw = filtRaw[gi];
        assign fIf.tick = filtTick[gi];
        assign filtHeld[gi] = fIf.held;
        // Index 0 short base, 1 and 2 plain cycles, the rest long base
        scs_filter #(
            .LIMIT(LIM[gi]),
            .BOTH_WAYS(BOTH[gi])
        ) u_filt (
            .ref_clk(ref_clk),
            .reset(reset),
            .f(fIf.filt)
        );
    end

    wire mainUvHeld = filtHeld[F_MAIN_UV];
    wire intUvHeld = filtHeld[F_INT_UV];
    wire extHeld = filtHeld[F_EXT];

    // Oscillator cross-check
    wire auxRise = auxClk && !auxPrev;
    // Monitoring waits for good internal supply, a released line and a read clock flag
    wire monitorOn = !control[CT_MON_STOP] && !intUvHeld && seqState == SEQ_RUN
                     && !resetFlags[RF_CLOCK];
    wire auxStopped = (auxIdle == SHORT_LAST);
    wire auxMismatch = (auxCount < AUX_MIN) || (auxCount > AUX_MAX);
    // One verdict per window, so a mismatch fault follows its window end
    assign clockFaultEvent = monitorOn && (auxStopped
                             || (longTick && auxMismatch));

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            auxPrev <= 1'b0;
            auxCount <= '0;
            auxLast <= '0;
            auxIdle <= '0;
        end else begin
            auxPrev <= auxClk;
            if (longTick) begin
                auxLast <= auxCount;
                auxCount <= {15'h0000, auxRise};
            end else if (auxRise && auxCount != 16'hffff) begin
                auxCount <= auxCount + 16'h0001;
            end
            if (auxRise || !monitorOn) begin
                auxIdle <= '0;
            end else if (!auxStopped) begin
                auxIdle <= auxIdle + 1'b1;
            end
        end
    end

    // Reset sequencer
    wire resetCause = mainUvHeld || intUvHeld || clockFaultEvent;
    wire recDone = (recCount == REC_LAST);

    always_comb begin
        next_seqState = seqState;
        unique case (seqState)
            SEQ_RUN: begin
                if (resetCause) begin
                    next_seqState = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (!resetCause) begin
                    next_seqState = SEQ_RECOVER;
                end
            end
            SEQ_RECOVER: begin
                if (resetCause) begin
                    next_seqState = SEQ_HOLD;
                end else if (recDone) begin
                    next_seqState = SEQ_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seqState <= SEQ_HOLD;
            recCount <= '0;
            resetLineOut <= 1'b0;
            resetLineOe <= 1'b1;
        end else begin
            seqState <= next_seqState;
            recCount <= (next_seqState == SEQ_RECOVER && seqState == SEQ_RECOVER)
                        ? recCount + 1'b1 : '0;
            resetLineOut <= 1'b0;
            resetLineOe <= (next_seqState != SEQ_RUN);
        end
    end

    // Register decode
    wire inReset = (seqState != SEQ_RUN) || extHeld;
    wire selResetFlags = (regAddr == OFS_RESET_FLAGS);
    wire selControl = (regAddr == OFS_CONTROL);
    wire selClear = (regAddr == OFS_CLEAR);
    wire readFlags = regRead && selResetFlags;
    wire writeControl = regWrite && selControl;
    wire writeClear = regWrite && selClear;
    wire [FC_W-1:0] clearNow = clearStage ? clearBits : '0;
    wire [RF_W-1:0] flagSet;
    wire [FC_W-1:0] faultSet;
    assign flagSet[RF_CLOCK] = clockFaultEvent;
    assign flagSet[RF_INT_UV] = intUvHeld;
    assign flagSet[RF_MAIN_UV] = mainUvHeld;
    assign flagSet[RF_EXT] = extHeld;
    assign faultSet[FL_PWR_UV] = filtHeld[F_PWR_UV];
    assign faultSet[FL_GND_LOSS] = filtHeld[F_GND];
    assign faultSet[FL_PWR_OV] = filtHeld[F_PWR_OV];

    logic [DATA_W-1:0] readMux;
    always_comb begin
        readMux = '0;
        unique case (regAddr)
            OFS_RESET_FLAGS: readMux[RF_W-1:0] = resetFlags;
            OFS_CONTROL: readMux[CT_W-1:0] = control;
            OFS_FAULTS: readMux[FL_TEMP:0] = {filtHeld[F_TEMP], stickyFaults};
            OFS_CLEAR: readMux[FC_W-1:0] = clearBits;
            OFS_CLK_COUNT: readMux = auxLast;
            OFS_GATE_LOW: readMux[9:0] = gateRegulatorLow;
            OFS_GATE_HIGH: readMux[9:0] = gateRegulatorHigh;
            default: readMux = '0;
        endcase
    end

    // Reset flags survive internal resets; set wins over clear on read
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            resetFlags <= '0;
        end else begin
            resetFlags <= (readFlags ? '0 : resetFlags) | flagSet;
        end
    end

    // Control and sticky faults return to defaults while the device is in reset
    always_ff @(posedge ref_clk) begin
        if (reset || inReset) begin
            control <= CONTROL_RESET;
            stickyFaults <= '0;
        end else begin
            if (writeControl) begin
                control <= regWdata[CT_W-1:0];
            end
            // Latched so that an open ground still reads 1 after the ground reconnects
            stickyFaults <= (stickyFaults & ~clearNow) | faultSet;
        end
    end

    // Clear bits: clear acts in the cycle after the write, bits drop one cycle later
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clearBits <= '0;
            clearStage <= 1'b0;
        end else if (writeClear) begin
            clearBits <= regWdata[FC_W-1:0];
            clearStage <= 1'b1;
        end else begin
            clearBits <= clearStage ? clearBits : '0;
            clearStage <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            regRdata <= '0;
            spreadEnable <= 1'b0;
            spreadDepthSelect <= 1'b0;
            groundLossFlag <= 1'b0;
            clockFaultResetFlag <= 1'b0;
        end else begin
            regRdata <= regRead ? readMux : '0;
            spreadEnable <= control[CT_SPREAD_EN];
            spreadDepthSelect <= control[CT_SPREAD_DEPTH];
            groundLossFlag <= stickyFaults[FL_GND_LOSS];
            clockFaultResetFlag <= resetFlags[RF_CLOCK];
        end
    end
endmodule

// File: verification/scs_supervisor_asserts.sv
`timescale 1ns/1ps
module scs_supervisor_asserts
    import scs_pkg::*;
#(
    parameter int LONG_CYCLES = 64,
    parameter int INT_UV_CYCLES = 20,
    parameter int RECOVERY_CYCLES = 30
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [scs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [scs_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    // Conditions
    input wire logic mainSupplyUv,
    input wire logic internalSupplyUv,
    input wire logic groundLossRaw,
    // Outputs
    input wire logic resetLineOut,
    input wire logic resetLineOe,
    input wire logic spreadDepthSelect,
    input wire logic groundLossFlag,
    input wire logic clockFaultResetFlag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    int uvRun;
    int intRun;
    int gndRun;
    int quietRun;
    wire logic depthWrite = regWrite && regAddr == OFS_CONTROL && regWdata[CT_SPREAD_DEPTH];
    wire logic flagRead = regRead && regAddr == OFS_RESET_FLAGS;
    wire logic gndClear = regWrite && regAddr == OFS_CLEAR && regWdata[FL_GND_LOSS];
    // Run lengths restart the cycle a condition drops; quietRun restarts while either supply condition holds
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            uvRun <= 0;
            intRun <= 0;
            gndRun <= 0;
            quietRun <= 0;
        end else begin
            uvRun <= mainSupplyUv ? uvRun + 1 : 0;
            intRun <= internalSupplyUv ? intRun + 1 : 0;
            gndRun <= groundLossRaw ? gndRun + 1 : 0;
            quietRun <= (mainSupplyUv || internalSupplyUv) ? 0 : quietRun + 1;
        end
    end
    property p_out_low; resetLineOut == 1'b0; endproperty
    a_out_low: assert property (p_out_low) else $error("line driven high");
    property p_recover; $fell(resetLineOe) |-> quietRun >= RECOVERY_CYCLES - 1; endproperty
    a_recover: assert property (p_recover) else $error("early release");
    property p_main_uv; uvRun == 2 * SHORT_CYC + 4 |-> resetLineOe; endproperty
    a_main_uv: assert property (p_main_uv) else $error("main uv no reset");
    property p_int_uv; intRun == INT_UV_CYCLES + 3 |-> resetLineOe; endproperty
    a_int_uv: assert property (p_int_uv) else $error("internal uv no reset");
    property p_gnd_set; gndRun == 2 * LONG_CYCLES + 4 && !resetLineOe |-> groundLossFlag; endproperty
    a_gnd_set: assert property (p_gnd_set) else $error("ground flag missing");
    property p_gnd_rise; $rose(groundLossFlag) |-> gndRun >= LONG_CYCLES; endproperty
    a_gnd_rise: assert property (p_gnd_rise) else $error("ground flag early");
    property p_clk_reset; $rose(clockFaultResetFlag) |-> ##[0:2] resetLineOe; endproperty
    a_clk_reset: assert property (p_clk_reset) else $error("clock fault no reset");
    property p_depth; $rose(spreadDepthSelect) |-> $past(depthWrite) || $past(depthWrite, 2); endproperty
    a_depth: assert property (p_depth) else $error("depth without write");
    property p_flag_read; $fell(clockFaultResetFlag) |-> $past(flagRead) || $past(flagRead, 2); endproperty
    a_flag_read: assert property (p_flag_read) else $error("clock flag lost");
    property p_clear; $fell(groundLossFlag) && !resetLineOe |-> $past(gndClear, 2) || $past(gndClear, 3); endproperty
    a_clear: assert property (p_clear) else $error("ground flag lost");
endmodule
bind scs_supervisor scs_supervisor_asserts #(.LONG_CYCLES(LONG_CYCLES),
    .INT_UV_CYCLES(INT_UV_CYCLES), .RECOVERY_CYCLES(RECOVERY_CYCLES)) chk_i (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .mainSupplyUv(mainSupplyUv),
    .internalSupplyUv(internalSupplyUv), .groundLossRaw(groundLossRaw),
    .resetLineOut(resetLineOut), .resetLineOe(resetLineOe), .spreadDepthSelect(spreadDepthSelect),
    .groundLossFlag(groundLossFlag), .clockFaultResetFlag(clockFaultResetFlag));

// File: verification/scs_host_model.sv
`timescale 1ns/1ps
module scs_host_model (
    // Clock
    input wire logic ref_clk,
    // Device side of the wire
    input wire logic resetLineOut,
    input wire logic resetLineOe,
    // Bench request
    input wire logic [15:0] pullLen,
    input wire logic pullStart,
    // Resolved wire
    output logic resetLineLevel
);
    logic [15:0] pullLeft = 16'h0000;
    // Short pulls are only asked for when the glitch filter is under test
    always @(posedge ref_clk) begin
        if (pullStart) begin
            pullLeft <= pullLen;
        end else if (pullLeft != 16'h0000) begin
            pullLeft <= pullLeft - 16'h0001;
        end
    end
    // Pull-up holds the wire high unless either party sinks it
    assign resetLineLevel = ((resetLineOe && !resetLineOut) || pullLeft != 16'h0000) ? 1'b0 : 1'b1;
endmodule

// File: verification/tb_supply_clock_supervisor.sv
`timescale 1ns/1ps
module tb_supply_clock_supervisor;
    import scs_pkg::*;
    localparam int LONG = 1500;
    localparam int RECOV = 30;
    localparam int AUX_NOM = LONG * 14 / 40;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [5:0] cond = 6'h00;
    logic auxClk = 1'b0;
    logic auxRun = 1'b1;
    int auxHalf = 36;
    logic [15:0] pullLen = 16'h0000;
    logic pullStart = 1'b0;
    logic [DATA_W-1:0] regRdata, d;
    logic resetLineIn, resetLineOut, resetLineOe, spreadEnable, spreadDepthSelect;
    logic groundLossFlag, clockFaultResetFlag;
    int err_total = 0;
    int total_checks = 0;
    int src[4] = '{4, 2, 3, 5};
    int fbit[4] = '{FL_GND_LOSS, FL_PWR_OV, FL_PWR_UV, FL_TEMP};
    always #12.5 ref_clk = ~ref_clk;
    // These half periods never put an aux edge on a rising main clock edge
    always #(auxHalf) auxClk = auxRun ? ~auxClk : auxClk;
    scs_supervisor #(.LONG_CYCLES(LONG), .INT_UV_CYCLES(20), .RECOVERY_CYCLES(RECOV),
        .AUX_EXPECTED(AUX_NOM)) dut (
        .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .mainSupplyUv(cond[0]), .internalSupplyUv(cond[1]), .powerOv(cond[2]),
        .powerUv(cond[3]), .groundLossRaw(cond[4]), .dieTempHigh(cond[5]), .auxClk(auxClk),
        .gateRegulatorLow(10'h2a5), .gateRegulatorHigh(10'h15a),
        .resetLineIn(resetLineIn), .resetLineOut(resetLineOut), .resetLineOe(resetLineOe),
        .spreadEnable(spreadEnable), .spreadDepthSelect(spreadDepthSelect),
        .groundLossFlag(groundLossFlag), .clockFaultResetFlag(clockFaultResetFlag));
    scs_host_model host (.ref_clk(ref_clk), .resetLineOut(resetLineOut),
        .resetLineOe(resetLineOe), .pullLen(pullLen), .pullStart(pullStart),
        .resetLineLevel(resetLineIn));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic setc(input int i, input logic v);
        @(posedge ref_clk);
        cond[i] <= v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkrd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
        rd(a);
        chk($sformatf("reg %h", a), exp, d & m);
    endtask
    task automatic pull(input int n);
        @(posedge ref_clk);
        pullLen <= 16'(n);
        pullStart <= 1'b1;
        @(posedge ref_clk);
        pullStart <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        cyc(RECOV + 5);
        chk("line", 16'h0, 16'(resetLineOe));
        rd(OFS_RESET_FLAGS);
        chkrd(8'h24, 16'hffff, 16'h0000);
        chkrd(OFS_GATE_LOW, 16'hffff, 16'h02a5);
        chkrd(OFS_GATE_HIGH, 16'hffff, 16'h015a);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CONTROL, 16'(i));
            cyc(2);
            chk("depth", 16'(i / 2), 16'(spreadDepthSelect));
            chk("spread", 16'(i % 2), 16'(spreadEnable));
        end
        pull(40);
        cyc(60);
        chkrd(OFS_RESET_FLAGS, 16'h8, 16'h0);
        pull(120);
        cyc(140 + RECOV);
        chkrd(OFS_RESET_FLAGS, 16'h8, 16'h8);
        chkrd(OFS_RESET_FLAGS, 16'h8, 16'h0);
        chkrd(OFS_CONTROL, 16'hffff, 16'h0000);
        setc(0, 1'b1);
        cyc(300);
        chk("line", 16'h0, 16'(resetLineOe));
        cyc(1500);
        chk("line", 16'h1, 16'(resetLineOe));
        setc(0, 1'b0);
        cyc(RECOV - 5);
        chk("line", 16'h1, 16'(resetLineOe));
        cyc(10);
        chk("line", 16'h0, 16'(resetLineOe));
        chkrd(OFS_RESET_FLAGS, 16'h4, 16'h4);
        setc(1, 1'b1);
        cyc(10);
        chk("line", 16'h0, 16'(resetLineOe));
        cyc(20);
        chk("line", 16'h1, 16'(resetLineOe));
        setc(1, 1'b0);
        cyc(RECOV + 10);
        chkrd(OFS_RESET_FLAGS, 16'h2, 16'h2);
        for (int k = 0; k < 4; k++) begin
            setc(src[k], 1'b1);
            cyc(LONG - 100);
            chkrd(OFS_FAULTS, 16'(1 << fbit[k]), 16'h0);
            cyc(LONG + 200);
            chkrd(OFS_FAULTS, 16'(1 << fbit[k]), 16'(1 << fbit[k]));
            setc(src[k], 1'b0);
        end
        cyc(2 * LONG + 20);
        chkrd(OFS_FAULTS, 16'hf, 16'h7);
        chk("ground", 16'h1, 16'(groundLossFlag));
        rd(OFS_CLK_COUNT);
        chk("aux count", 16'h1, 16'(d >= AUX_NOM - 8 && d <= AUX_NOM + 8));
        wr(OFS_CLEAR, 16'h2);
        chkrd(OFS_CLEAR, 16'h7, 16'h2);
        cyc(3);
        chkrd(OFS_CLEAR, 16'h7, 16'h0);
        chkrd(OFS_FAULTS, 16'hf, 16'h5);
        wr(OFS_CLEAR, 16'h5);
        cyc(4);
        chkrd(OFS_FAULTS, 16'hf, 16'h0);
        chk("ground", 16'h0, 16'(groundLossFlag));
        rd(OFS_RESET_FLAGS);
        auxRun <= 1'b0;
        // The stop fault is one event, so the line is only held for the recovery time
        cyc(742);
        chk("clock flag", 16'h1, 16'(clockFaultResetFlag));
        chk("line", 16'h1, 16'(resetLineOe));
        auxHalf = 75;
        auxRun <= 1'b1;
        cyc(2 * LONG + RECOV + 100);
        chk("line", 16'h0, 16'(resetLineOe));
        chkrd(OFS_RESET_FLAGS, 16'h1, 16'h1);
        cyc(3);
        chk("clock flag", 16'h0, 16'(clockFaultResetFlag));
        cyc(2 * LONG + 100);
        chk("clock flag", 16'h1, 16'(clockFaultResetFlag));
        tally_and_finish();
    end
endmodule
